// ==== rtl/i2c_status_flag_logic.sv ====
// Status flags of a two-wire serial bus unit with a Wishbone register port.
`timescale 1ns/1ps
`include "i2c_status_defs.svh"

////////////////////////////////////////////////////////////////////////////////

// How it works
// - At slave acknowledge end the nack flag takes one for nack, zero for ack.
// - Transmit-active sets at master transmit start, clears at acknowledge end.
// - Bus collision in master operation sets a sticky collision flag.
// - General call address match sets a flag that Stop clears.
// - Second byte of matching ten-bit address sets a flag Stop clears.
// - Transmit register write while busy is dropped and sets write collision.
// - Byte completing while receive register still full sets overflow flag.
// - Slave address match clears data-or-address; slave data byte sets it.
// - Stop indicator sets on Stop, clears on Start or Repeated Start.
// - Status bits thirteen to eleven read zero and ignore writes.
module i2c_status_flag_logic (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [`ADR_W-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  input wire logic link_clk_i,
  input wire logic link_busy_i,
  input wire logic link_tx_start_i,
  input wire logic link_ack_end_i,
  input wire logic link_nack_i,
  input wire logic link_collision_i,
  input wire logic link_gen_call_i,
  input wire logic link_ten_bit_i,
  input wire logic link_addr_match_i,
  input wire logic link_data_rx_i,
  input wire logic link_start_i,
  input wire logic link_stop_i,
  input wire logic link_byte_done_i,
  input wire logic [7:0] rx_shift_reg_i,
  input wire logic link_tx_taken_i,
  output logic [7:0] tx_holding_o,
  output logic tx_full_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Link clock domain.

  logic link_rst;
  logic nack_link_reg;
  logic [7:0] rx_byte_link_reg;
  logic [`EV_W-1:0] link_ev;

  // The link clock may stop between frames, so its reset is a synced copy.
  level_sync #(.W(1)) u_link_rst (
    .clk_i(link_clk_i),
    .rst_i(1'b0),
    .d_i(rst_i),
    .q_o(link_rst)
  );

  always_comb begin
    link_ev = '0;
    link_ev[i2c_status_pkg::EV_TX_START] = link_tx_start_i;
    link_ev[i2c_status_pkg::EV_ACK_END] = link_ack_end_i;
    link_ev[i2c_status_pkg::EV_COLLISION] = link_collision_i;
    link_ev[i2c_status_pkg::EV_GEN_CALL] = link_gen_call_i;
    link_ev[i2c_status_pkg::EV_TEN_BIT] = link_ten_bit_i;
    link_ev[i2c_status_pkg::EV_ADDR_MATCH] = link_addr_match_i;
    link_ev[i2c_status_pkg::EV_DATA_RX] = link_data_rx_i;
    link_ev[i2c_status_pkg::EV_START] = link_start_i;
    link_ev[i2c_status_pkg::EV_STOP] = link_stop_i;
    link_ev[i2c_status_pkg::EV_BYTE_DONE] = link_byte_done_i;
    link_ev[i2c_status_pkg::EV_TX_TAKEN] = link_tx_taken_i;
  end

  // Values that travel with an event are frozen until the next such event,
  // which lies a whole byte away, far beyond the crossing latency.
  always_ff @(posedge link_clk_i) begin
    if (link_rst) begin
      nack_link_reg <= 1'b0;
    end else if (link_ack_end_i) begin
      nack_link_reg <= link_nack_i;
    end
  end

  always_ff @(posedge link_clk_i) begin
    if (link_rst) begin
      rx_byte_link_reg <= `BYTE_RESET;
    end else if (link_byte_done_i) begin
      rx_byte_link_reg <= rx_shift_reg_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Crossing into the register clock domain.

  logic [`EV_W-1:0] ev;
  logic busy_sync;

  event_cross #(.W(`EV_W)) u_ev_cross (
    .src_clk_i(link_clk_i),
    .src_rst_i(link_rst),
    .ev_i(link_ev),
    .dst_clk_i(clk_i),
    .dst_rst_i(rst_i),
    .ev_o(ev)
  );

  level_sync #(.W(1)) u_busy_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(link_busy_i),
    .q_o(busy_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone slave: one wait state, ack for one cycle, unmapped reads zero.

  logic access;
  logic wr;
  logic rd;
  logic hit_status;
  logic hit_tx;
  logic hit_rx;

  assign access = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr = access & wb_we_i;
  assign rd = access & ~wb_we_i;

  always_comb begin
    hit_status = 1'b0;
    hit_tx = 1'b0;
    hit_rx = 1'b0;
    if (wb_adr_i == `OFF_STATUS) begin
      hit_status = 1'b1;
    end else if (wb_adr_i == `OFF_TX_HOLD) begin
      hit_tx = 1'b1;
    end else if (wb_adr_i == `OFF_RX_HOLD) begin
      hit_rx = 1'b1;
    end
  end

  // True when a status write clears bit pos: its lane enabled, data zero.
  function automatic logic sw_clear(input logic [31:0] dat,
                                    input logic [3:0] sel,
                                    input int pos);
    sw_clear = sel[pos / 8] & ~dat[pos];
  endfunction

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= access;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status flags. Where a hardware set meets a software clear, set wins.

  logic nack_reg;
  logic tx_active_reg;
  logic collision_reg;
  logic gen_call_reg;
  logic ten_bit_reg;
  logic wr_coll_reg;
  logic rx_ovf_reg;
  logic data_addr_reg;
  logic stop_reg;
  logic rx_full_reg;
  logic [7:0] rx_holding_reg;
  logic wr_clear;
  logic tx_busy;

  assign wr_clear = wr & hit_status;
  assign tx_busy = busy_sync | tx_active_reg | tx_full_o;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      nack_reg <= 1'b0;
    end else if (ev[i2c_status_pkg::EV_ACK_END]) begin
      nack_reg <= nack_link_reg;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_active_reg <= 1'b0;
    end else if (ev[i2c_status_pkg::EV_TX_START]) begin
      tx_active_reg <= 1'b1;
    end else if (ev[i2c_status_pkg::EV_ACK_END]) begin
      tx_active_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      collision_reg <= 1'b0;
    end else if (ev[i2c_status_pkg::EV_COLLISION]) begin
      collision_reg <= 1'b1;
    end else if (wr_clear &&
                 sw_clear(wb_dat_i, wb_sel_i, `BIT_COLLISION)) begin
      collision_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gen_call_reg <= 1'b0;
    end else if (ev[i2c_status_pkg::EV_GEN_CALL]) begin
      gen_call_reg <= 1'b1;
    end else if (ev[i2c_status_pkg::EV_STOP]) begin
      gen_call_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ten_bit_reg <= 1'b0;
    end else if (ev[i2c_status_pkg::EV_TEN_BIT]) begin
      ten_bit_reg <= 1'b1;
    end else if (ev[i2c_status_pkg::EV_STOP]) begin
      ten_bit_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_coll_reg <= 1'b0;
    end else if (wr && hit_tx && tx_busy) begin
      wr_coll_reg <= 1'b1;
    end else if (wr_clear &&
                 sw_clear(wb_dat_i, wb_sel_i, `BIT_WR_COLL)) begin
      wr_coll_reg <= 1'b0;
    end
  end

  // A read that empties the holding register in the same cycle as a new
  // byte arrives makes room for it, so that byte is not counted as lost.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_ovf_reg <= 1'b0;
    end else if (ev[i2c_status_pkg::EV_BYTE_DONE] && rx_full_reg &&
                 !(rd && hit_rx)) begin
      rx_ovf_reg <= 1'b1;
    end else if (wr_clear &&
                 sw_clear(wb_dat_i, wb_sel_i, `BIT_RX_OVF)) begin
      rx_ovf_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_full_reg <= 1'b0;
      rx_holding_reg <= `BYTE_RESET;
    end else if (ev[i2c_status_pkg::EV_BYTE_DONE] &&
                 (!rx_full_reg || (rd && hit_rx))) begin
      rx_full_reg <= 1'b1;
      rx_holding_reg <= rx_byte_link_reg;
    end else if (rd && hit_rx) begin
      rx_full_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_addr_reg <= 1'b0;
    end else if (ev[i2c_status_pkg::EV_DATA_RX]) begin
      data_addr_reg <= 1'b1;
    end else if (ev[i2c_status_pkg::EV_ADDR_MATCH]) begin
      data_addr_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stop_reg <= 1'b0;
    end else if (ev[i2c_status_pkg::EV_STOP]) begin
      stop_reg <= 1'b1;
    end else if (ev[i2c_status_pkg::EV_START]) begin
      stop_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit holding register; a rejected write leaves it untouched.

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_full_o <= 1'b0;
      tx_holding_o <= `BYTE_RESET;
    end else if (wr && hit_tx && !tx_busy && wb_sel_i[0]) begin
      tx_full_o <= 1'b1;
      tx_holding_o <= wb_dat_i[7:0];
    end else if (ev[i2c_status_pkg::EV_TX_TAKEN]) begin
      tx_full_o <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data.

  i2c_status_pkg::status_word_t status_word;

  always_comb begin
    status_word = `STATUS_RESET;
    status_word[`BIT_NACK] = nack_reg;
    status_word[`BIT_TX_ACTIVE] = tx_active_reg;
    status_word[`BIT_COLLISION] = collision_reg;
    status_word[`BIT_GEN_CALL] = gen_call_reg;
    status_word[`BIT_TEN_BIT] = ten_bit_reg;
    status_word[`BIT_WR_COLL] = wr_coll_reg;
    status_word[`BIT_RX_OVF] = rx_ovf_reg;
    status_word[`BIT_DATA_ADDR] = data_addr_reg;
    status_word[`BIT_STOP] = stop_reg;
    status_word[`BIT_RX_FULL] = rx_full_reg;
    status_word[`BIT_TX_FULL] = tx_full_o;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (rd && hit_status) begin
      wb_dat_o <= {16'h0000, status_word};
    end else if (rd && hit_tx) begin
      wb_dat_o <= {24'h00_0000, tx_holding_o};
    end else if (rd && hit_rx) begin
      wb_dat_o <= {24'h00_0000, rx_holding_reg};
    end else begin
      wb_dat_o <= 32'h0000_0000;
    end
  end

endmodule

// ==== shared/i2c_status_defs.svh ====
// Offsets, field positions, reset values and event vector width of the status block.
`ifndef I2C_STATUS_DEFS_SVH
`define I2C_STATUS_DEFS_SVH

`define ADR_W 8
`define OFF_STATUS 8'h00
`define OFF_TX_HOLD 8'h04
`define OFF_RX_HOLD 8'h08

`define STATUS_RESET 16'h0000
`define BYTE_RESET 8'h00

`define BIT_NACK 15
`define BIT_TX_ACTIVE 14
`define BIT_COLLISION 10
`define BIT_GEN_CALL 9
`define BIT_TEN_BIT 8
`define BIT_WR_COLL 7
`define BIT_RX_OVF 6
`define BIT_DATA_ADDR 5
`define BIT_STOP 4
`define BIT_RX_FULL 1
`define BIT_TX_FULL 0

`define EV_W 11

`endif

// ==== shared/i2c_status_pkg.sv ====
// Types used by the status block: its status word and link event indices.
package i2c_status_pkg;

  typedef logic [15:0] status_word_t;

  // Index of each link event in the crossing vector.
  typedef enum logic [3:0] {
    EV_TX_START = 4'h0,
    EV_ACK_END = 4'h1,
    EV_COLLISION = 4'h2,
    EV_GEN_CALL = 4'h3,
    EV_TEN_BIT = 4'h4,
    EV_ADDR_MATCH = 4'h5,
    EV_DATA_RX = 4'h6,
    EV_START = 4'h7,
    EV_STOP = 4'h8,
    EV_BYTE_DONE = 4'h9,
    EV_TX_TAKEN = 4'ha
  } ev_idx_e;

endpackage

// ==== rtl/level_sync.sv ====
// Two-flop synchroniser for levels entering a clock domain.
`timescale 1ns/1ps

module level_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta_reg;

  // The first stage feeds the second stage and nothing else.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_reg <= '0;
      q_o <= '0;
    end else begin
      meta_reg <= d_i;
      q_o <= meta_reg;
    end
  end

endmodule

// ==== rtl/event_cross.sv ====
// Toggle crossing that carries one-cycle events between two clocks.
`timescale 1ns/1ps

module event_cross #(
  parameter int W = 1
) (
  input wire logic src_clk_i,
  input wire logic src_rst_i,
  input wire logic [W-1:0] ev_i,
  input wire logic dst_clk_i,
  input wire logic dst_rst_i,
  output logic [W-1:0] ev_o
);

  logic [W-1:0] tog_reg;
  logic [W-1:0] tog_sync;
  logic [W-1:0] tog_prev_reg;

  // A toggle survives a source clock that stops right after the event.
  always_ff @(posedge src_clk_i) begin
    if (src_rst_i) begin
      tog_reg <= '0;
    end else begin
      tog_reg <= tog_reg ^ ev_i;
    end
  end

  level_sync #(.W(W)) u_sync (
    .clk_i(dst_clk_i),
    .rst_i(dst_rst_i),
    .d_i(tog_reg),
    .q_o(tog_sync)
  );

  always_ff @(posedge dst_clk_i) begin
    if (dst_rst_i) begin
      tog_prev_reg <= '0;
      ev_o <= '0;
    end else begin
      tog_prev_reg <= tog_sync;
      ev_o <= tog_sync ^ tog_prev_reg;
    end
  end

endmodule

// ==== testbench/i2c_status_checker_assertions.sv ====
// Assertions on the status block's register port and transmit holding.
`timescale 1ns/1ps
`include "i2c_status_defs.svh"

module i2c_status_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [`ADR_W-1:0] wb_adr_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic [7:0] tx_holding_o,
  input wire logic tx_full_o
);
  logic req;
  logic tx_wr;
  logic st_rd;
  logic rd;
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign tx_wr = req && wb_we_i && wb_adr_i == `OFF_TX_HOLD;
  assign rd = wb_ack_o && !wb_we_i;
  assign st_rd = rd && wb_adr_i == `OFF_STATUS;
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////////////////
  property p_ack;
    req |=> wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("no ack");
  property p_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_pulse: assert property (p_pulse) else $error("long ack");
  property p_rst;
    $fell(rst_i) |-> !wb_ack_o && !tx_full_o && tx_holding_o == 8'h00;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  property p_idle;
    !wb_ack_o |-> wb_dat_o == 32'h0;
  endproperty
  a_idle: assert property (p_idle) else $error("idle data");
  property p_gap;
    st_rd |-> wb_dat_o[31:16] == 16'h0 && wb_dat_o[13:11] == 3'h0;
  endproperty
  a_gap: assert property (p_gap) else $error("unused bits");
  property p_unmap;
    rd && !(wb_adr_i inside {`OFF_STATUS, `OFF_TX_HOLD, `OFF_RX_HOLD})
      |-> wb_dat_o == 32'h0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped");
  // A write while the holding register is full must leave the held byte alone through its ack.
  property p_busy;
    tx_wr && tx_full_o |=> $stable(tx_holding_o) [*2];
  endproperty
  a_busy: assert property (p_busy) else $error("busy write");
  property p_src;
    $changed(tx_holding_o) |-> $past(tx_wr) || $past(tx_wr, 2);
  endproperty
  a_src: assert property (p_src) else $error("stray tx");
endmodule

bind i2c_status_flag_logic i2c_status_checker i_i2c_status_checker (
  .clk_i, .rst_i, .wb_adr_i, .wb_we_i, .wb_cyc_i, .wb_stb_i,
  .wb_ack_o, .wb_dat_o, .tx_holding_o, .tx_full_o);

// ==== testbench/i2c_link_model.sv ====
// Link-side model: pulses link events on its own gated clock.
`timescale 1ns/1ps
`include "i2c_status_defs.svh"

module i2c_link_model (
  output logic link_clk_o,
  output logic [`EV_W-1:0] ev_o,
  output logic nack_o,
  output logic [7:0] rx_byte_o,
  output logic busy_o
);
  logic run;
  // The clock runs through reset, then only inside frames.
  initial begin
    link_clk_o = 1'b0;
    ev_o = '0;
    nack_o = 1'b0;
    rx_byte_o = 8'h00;
    busy_o = 1'b0;
    run = 1'b1;
    #3;
    forever #6 link_clk_o = run ? ~link_clk_o : 1'b0;
  end
  initial #90 run = 1'b0;
  task automatic send(input int i, input logic nk, input logic [7:0] b);
    run = 1'b1;
    repeat (3) @(posedge link_clk_o);
    ev_o[i] <= 1'b1;
    nack_o <= nk;
    rx_byte_o <= b;
    busy_o <= 1'b1;
    @(posedge link_clk_o);
    ev_o <= '0;
    // Released data is inverted so nobody relies on a stale value.
    nack_o <= ~nk;
    rx_byte_o <= ~b;
    repeat (8) @(posedge link_clk_o);
    busy_o <= 1'b0;
    @(posedge link_clk_o);
    run = 1'b0;
  endtask
endmodule

// ==== testbench/i2c_status_flag_logic_bench.sv ====
// Self-checking bench for the status flag block.
`timescale 1ns/1ps
`include "i2c_status_defs.svh"
`define CHK(n, e, g) \
  begin \
    checked++; \
    if ((g) !== (e)) begin \
      err_count++; \
      $display("unexpected %s: expected %h, seen %h", n, e, g); \
    end \
  end

module i2c_status_flag_logic_bench;
  logic clk_i;
  logic rst_i;
  logic [`ADR_W-1:0] wb_adr_i;
  logic [31:0] wb_dat_i;
  logic [3:0] wb_sel_i;
  logic wb_we_i;
  logic wb_cyc_i;
  logic wb_stb_i;
  logic wb_ack_o;
  logic [31:0] wb_dat_o;
  logic link_clk_i;
  logic link_busy_i;
  logic link_nack_i;
  logic [7:0] rx_shift_reg_i;
  logic [7:0] tx_holding_o;
  logic tx_full_o;
  logic [`EV_W-1:0] ev;
  logic [31:0] d;
  int err_count;
  int checked;

  i2c_status_flag_logic i_i2c_status_flag_logic (
    .clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i,
    .wb_cyc_i, .wb_stb_i, .wb_ack_o, .wb_dat_o, .link_clk_i,
    .link_busy_i, .link_nack_i, .rx_shift_reg_i, .tx_holding_o,
    .tx_full_o, .link_tx_start_i(ev[0]), .link_ack_end_i(ev[1]),
    .link_collision_i(ev[2]), .link_gen_call_i(ev[3]),
    .link_ten_bit_i(ev[4]), .link_addr_match_i(ev[5]),
    .link_data_rx_i(ev[6]), .link_start_i(ev[7]), .link_stop_i(ev[8]),
    .link_byte_done_i(ev[9]), .link_tx_taken_i(ev[10]));

  i2c_link_model i_i2c_link_model (
    .link_clk_o(link_clk_i), .ev_o(ev), .nack_o(link_nack_i),
    .rx_byte_o(rx_shift_reg_i), .busy_o(link_busy_i));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic wb(input logic [7:0] a, input logic w,
                    input logic [31:0] v, input logic [3:0] s);
    int n;
    n = 0;
    wb_adr_i <= a;
    wb_we_i <= w;
    wb_dat_i <= v;
    wb_sel_i <= s;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) err_count++;
    d = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic st;
    wb(`OFF_STATUS, 1'b0, 32'h0, 4'hf);
  endtask
  task automatic lk(input int i, input logic nk, input logic [7:0] b);
    i_i2c_link_model.send(i, nk, b);
    @(posedge clk_i);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    st();
    `CHK("status", 32'h0, d)
    wb(8'h0c, 1'b0, 32'h0, 4'hf);
    `CHK("unmapped", 32'h0, d)
  endtask
  task automatic t_tx;
    lk(0, 1'b0, 8'h00);
    st();
    `CHK("tx active", 1'b1, d[`BIT_TX_ACTIVE])
    lk(1, 1'b1, 8'h00);
    st();
    `CHK("tx active", 1'b0, d[`BIT_TX_ACTIVE])
    `CHK("nack", 1'b1, d[`BIT_NACK])
    lk(1, 1'b0, 8'h00);
    st();
    `CHK("nack", 1'b0, d[`BIT_NACK])
  endtask
  task automatic t_events;
    lk(3, 1'b0, 8'h00);
    lk(4, 1'b0, 8'h00);
    lk(6, 1'b0, 8'h00);
    st();
    `CHK("gen call", 1'b1, d[`BIT_GEN_CALL])
    `CHK("ten bit", 1'b1, d[`BIT_TEN_BIT])
    `CHK("data", 1'b1, d[`BIT_DATA_ADDR])
    lk(5, 1'b0, 8'h00);
    lk(8, 1'b0, 8'h00);
    st();
    `CHK("data", 1'b0, d[`BIT_DATA_ADDR])
    `CHK("stop", 1'b1, d[`BIT_STOP])
    `CHK("gen ten", 2'h0, d[9:8])
    lk(7, 1'b0, 8'h00);
    st();
    `CHK("stop", 1'b0, d[`BIT_STOP])
  endtask
  task automatic t_coll;
    lk(2, 1'b0, 8'h00);
    wb(`OFF_STATUS, 1'b1, 32'h0000ffff, 4'h3);
    wb(`OFF_STATUS, 1'b1, 32'h0, 4'h1);
    st();
    `CHK("collision", 1'b1, d[`BIT_COLLISION])
    `CHK("unused", 3'h0, d[13:11])
    wb(`OFF_STATUS, 1'b1, 32'h0, 4'h2);
    st();
    `CHK("collision", 1'b0, d[`BIT_COLLISION])
  endtask
  task automatic t_ovf;
    lk(9, 1'b0, 8'ha5);
    lk(9, 1'b0, 8'h5a);
    st();
    `CHK("overflow", 1'b1, d[`BIT_RX_OVF])
    wb(`OFF_RX_HOLD, 1'b0, 32'h0, 4'hf);
    `CHK("rx byte", 32'ha5, d)
    wb(`OFF_STATUS, 1'b1, 32'h0, 4'h1);
    st();
    `CHK("overflow", 1'b0, d[`BIT_RX_OVF])
  endtask
  task automatic t_wcol;
    wb(`OFF_TX_HOLD, 1'b1, 32'h3c, 4'h1);
    `CHK("tx full", 1'b1, tx_full_o)
    wb(`OFF_TX_HOLD, 1'b1, 32'h77, 4'h1);
    st();
    `CHK("tx byte", 8'h3c, tx_holding_o)
    `CHK("write coll", 1'b1, d[`BIT_WR_COLL])
    wb(`OFF_TX_HOLD, 1'b0, 32'h0, 4'hf);
    `CHK("tx read", 32'h3c, d)
    lk(10, 1'b0, 8'h00);
    wb(`OFF_STATUS, 1'b1, 32'h0, 4'h1);
    st();
    `CHK("write coll", 1'b0, d[`BIT_WR_COLL])
    `CHK("tx full", 1'b0, tx_full_o)
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("checks %0d, errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    rst_i = 1'b1;
    wb_adr_i = 8'h00;
    wb_dat_i = 32'h0;
    wb_sel_i = 4'h0;
    wb_we_i = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_tx();
    t_events();
    t_coll();
    t_ovf();
    t_wcol();
    tally_and_finish();
  end
  initial begin
    #100000;
    err_count++;
    tally_and_finish();
  end
endmodule
